// >>> hdl/sweep_pkg.sv
package sweep_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_SPAN = 8'h04;
  localparam logic [7:0] OFF_USER_DUR = 8'h08;
  localparam logic [7:0] OFF_TRIG_DLY = 8'h0C;
  localparam logic [7:0] OFF_GATE_DLY = 8'h10;
  localparam logic [7:0] OFF_GATE_LEN = 8'h14;
  localparam logic [7:0] OFF_VID_PCT = 8'h18;
  localparam logic [7:0] OFF_AVG = 8'h1C;
  localparam logic [7:0] OFF_STATUS = 8'h20;
  localparam logic [7:0] OFF_EFF_DUR = 8'h24;
  localparam logic [7:0] OFF_ELAPSED = 8'h28;
  localparam logic [7:0] OFF_NONE = 8'hFF;
  // control register fields
  localparam int CTRL_SINGLE = 0;
  localparam int CTRL_START = 1;
  localparam int CTRL_SRC_LO = 2;
  localparam int CTRL_FALL = 4;
  localparam int CTRL_MANUAL = 5;
  localparam int CTRL_GATE_SETUP = 6;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] AVG_RESET = 32'h0000_0001;
  localparam logic [31:0] VID_PCT_RESET = 32'h0000_0032;
  localparam logic [31:0] USER_DUR_RESET = 32'h0000_4E20;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // trigger sources
  typedef enum logic [1:0] {SRC_FREE = 2'h0, SRC_VIDEO = 2'h1, SRC_EXT = 2'h2,
                            SRC_GATED = 2'h3} trig_src_t;
  // sweep sequencer, gray along idle-arm-delay-sweep and arm-gate wait-gate delay-gate open
  typedef enum logic [2:0] {ST_IDLE = 3'h0, ST_ARM = 3'h1, ST_DELAY = 3'h3,
                            ST_SWEEP = 3'h2, ST_GATE_WAIT = 3'h5, ST_GATE_DLY = 3'h7,
                            ST_GATE_OPEN = 3'h6} sweep_state_t;
  // timing, clock period and tick in nanoseconds, tick also in clock cycles, all other durations are held in microseconds
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_NS = 1000;
  localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
  localparam logic [31:0] SPAN_MIN_US = 32'd20000;
  localparam logic [31:0] SPAN_STEP_MHZ = 32'd600;
  localparam logic [31:0] ZS_MIN_US = 32'd34;
  localparam logic [31:0] ZS_MAX_US = 32'd1000000000;
  localparam logic [31:0] TDLY_MAX_US = 32'd100000000;
  localparam logic [31:0] PCT_FULL = 32'd100;
endpackage

// >>> hdl/sweep_trigger_gate_control.sv
`timescale 1ns/1ps
module sweep_trigger_gate_control #(
  parameter int VIDEO_W = 12,
  parameter logic [31:0] REF_CODE = 32'h0000_0FFF
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ext_trig_pin,
  input wire logic [VIDEO_W-1:0] video_level,
  output logic acquiring,
  output logic sweep_start,
  output logic sweep_done,
  output logic [31:0] sweep_time_us
);
  initial
  begin
    if (VIDEO_W < 2 || VIDEO_W > 24)
      $error("VIDEO_W must be 2..24");
    if (REF_CODE >= (32'd1 << VIDEO_W))
      $error("REF_CODE must fit in VIDEO_W bits");
  end

  logic [31:0] ctrl, span_mhz, user_dur, trig_dly, gate_dly, gate_len, vid_pct, avg_cnt;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_en, start_req;
  sweep_pkg::sweep_state_t state;
  logic [31:0] elapsed, dly_cnt, gate_cnt, runs_left, eff_dur;
  logic [6:0] tick_div;
  logic tick;
  logic ext_s1, ext_s2, ext_prev, vid_prev;

  function automatic logic [7:0] reg_index(input logic [7:0] a);
    logic [7:0] r;
    r = sweep_pkg::OFF_NONE;
    if (a == sweep_pkg::OFF_CTRL) r = a;
    else if (a == sweep_pkg::OFF_SPAN) r = a;
    else if (a == sweep_pkg::OFF_USER_DUR) r = a;
    else if (a == sweep_pkg::OFF_TRIG_DLY) r = a;
    else if (a == sweep_pkg::OFF_GATE_DLY) r = a;
    else if (a == sweep_pkg::OFF_GATE_LEN) r = a;
    else if (a == sweep_pkg::OFF_VID_PCT) r = a;
    else if (a == sweep_pkg::OFF_AVG) r = a;
    else if (a == sweep_pkg::OFF_STATUS) r = a;
    else if (a == sweep_pkg::OFF_EFF_DUR) r = a;
    else if (a == sweep_pkg::OFF_ELAPSED) r = a;
    return r;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (strb[i]) r[i*8 +: 8] = nw[i*8 +: 8];
    return r;
  endfunction

  // clamp to 100 s, then truncate to the resolution of the decade
  function automatic logic [31:0] quant_delay(input logic [31:0] v);
    logic [31:0] c, g;
    c = (v > sweep_pkg::TDLY_MAX_US) ? sweep_pkg::TDLY_MAX_US : v;
    if (c < 32'd1000) g = 32'd10;
    else if (c < 32'd10000) g = 32'd100;
    else if (c < 32'd100000) g = 32'd1000;
    else if (c < 32'd1000000) g = 32'd10000;
    else if (c < 32'd10000000) g = 32'd100000;
    else g = 32'd1000000;
    return c - (c % g);
  endfunction

  // axi write channel: address and data taken in either order, then one response
  assign wr_en = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= sweep_pkg::RESP_OKAY;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        s_axi_awready <= 1'b0;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        s_axi_wready <= 1'b0;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_en)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (reg_index(aw_addr) == sweep_pkg::OFF_NONE) ?
                       sweep_pkg::RESP_SLVERR : sweep_pkg::RESP_OKAY;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // settings registers; status words are read only and writes to them are dropped
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ctrl <= sweep_pkg::CTRL_RESET;
      span_mhz <= 32'h0000_0000;
      user_dur <= sweep_pkg::USER_DUR_RESET;
      trig_dly <= 32'h0000_0000;
      gate_dly <= 32'h0000_0000;
      gate_len <= 32'h0000_0000;
      vid_pct <= sweep_pkg::VID_PCT_RESET;
      avg_cnt <= sweep_pkg::AVG_RESET;
    end
    else if (wr_en)
    begin
      if (aw_addr == sweep_pkg::OFF_CTRL) ctrl <= merge(ctrl, w_data, w_strb);
      else if (aw_addr == sweep_pkg::OFF_SPAN) span_mhz <= merge(span_mhz, w_data, w_strb);
      else if (aw_addr == sweep_pkg::OFF_USER_DUR) user_dur <= merge(user_dur, w_data, w_strb);
      else if (aw_addr == sweep_pkg::OFF_TRIG_DLY)
        trig_dly <= quant_delay(merge(trig_dly, w_data, w_strb));
      else if (aw_addr == sweep_pkg::OFF_GATE_DLY) gate_dly <= merge(gate_dly, w_data, w_strb);
      else if (aw_addr == sweep_pkg::OFF_GATE_LEN) gate_len <= merge(gate_len, w_data, w_strb);
      else if (aw_addr == sweep_pkg::OFF_VID_PCT) vid_pct <= merge(vid_pct, w_data, w_strb);
      else if (aw_addr == sweep_pkg::OFF_AVG) avg_cnt <= merge(avg_cnt, w_data, w_strb);
    end
  end

  // start command is a write-one pulse; a new request beats the clear
  logic start_wr;
  assign start_wr = wr_en && aw_addr == sweep_pkg::OFF_CTRL && w_strb[0] &&
                    w_data[sweep_pkg::CTRL_START];
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      start_req <= 1'b0;
    else if (start_wr)
      start_req <= 1'b1;
    else if (state == sweep_pkg::ST_IDLE)
      start_req <= 1'b0;
  end

  // gate setup holds span at zero; the stored span returns on exit
  logic [31:0] act_span, span_floor, vid_thr;
  logic [63:0] span_prod, thr_prod;
  logic single, gate_setup, fall, zero_span;
  sweep_pkg::trig_src_t src;
  assign gate_setup = ctrl[sweep_pkg::CTRL_GATE_SETUP];
  assign act_span = gate_setup ? 32'h0000_0000 : span_mhz;
  assign zero_span = act_span == 32'h0000_0000;
  assign single = ctrl[sweep_pkg::CTRL_SINGLE];
  assign fall = ctrl[sweep_pkg::CTRL_FALL];
  assign src = sweep_pkg::trig_src_t'(ctrl[sweep_pkg::CTRL_SRC_LO +: 2]);
  // span floor rounds up so the filter always has time to settle
  assign span_prod = 64'(act_span) * 64'(sweep_pkg::SPAN_MIN_US) +
                     64'(sweep_pkg::SPAN_STEP_MHZ) - 64'd1;
  assign span_floor = 32'(span_prod / 64'(sweep_pkg::SPAN_STEP_MHZ));
  // threshold in video codes, 100 percent sits at the reference level
  assign thr_prod = 64'(REF_CODE) * 64'(vid_pct);
  assign vid_thr = 32'(thr_prod / 64'(sweep_pkg::PCT_FULL));

  // effective sweep duration, registered to keep the divide off the fsm path
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      eff_dur <= sweep_pkg::USER_DUR_RESET;
    else if (zero_span)
      eff_dur <= (user_dur < sweep_pkg::ZS_MIN_US) ? sweep_pkg::ZS_MIN_US :
                 (user_dur > sweep_pkg::ZS_MAX_US) ? sweep_pkg::ZS_MAX_US : user_dur;
    else if (!ctrl[sweep_pkg::CTRL_MANUAL])
      eff_dur <= span_floor;
    else
      eff_dur <= (user_dur < span_floor) ? span_floor : user_dur;
  end

  // one microsecond tick shared by every timer
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      tick_div <= 7'h00;
      tick <= 1'b0;
    end
    else
    begin
      tick <= tick_div == 7'(sweep_pkg::TICK_CYCLES - 1);
      tick_div <= (tick_div == 7'(sweep_pkg::TICK_CYCLES - 1)) ? 7'h00 : tick_div + 7'h01;
    end
  end

  // trigger pin crosses from outside, two flops before anything looks at it
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ext_s1 <= 1'b0;
      ext_s2 <= 1'b0;
      ext_prev <= 1'b0;
      vid_prev <= 1'b0;
    end
    else
    begin
      ext_s1 <= ext_trig_pin;
      ext_s2 <= ext_s1;
      ext_prev <= ext_s2;
      vid_prev <= 32'(video_level) > vid_thr;
    end
  end

  logic ext_edge, gate_on, vid_hit, last_us;
  assign ext_edge = fall ? (ext_prev && !ext_s2) : (!ext_prev && ext_s2);
  assign gate_on = ext_edge; // gate opens on the active polarity edge
  assign vid_hit = !vid_prev && (32'(video_level) > vid_thr);
  assign last_us = tick && (elapsed + 32'd1 >= eff_dur);

  // sweep sequencer; events only count in arm and gate wait states
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state <= sweep_pkg::ST_IDLE;
      elapsed <= 32'h0000_0000;
      dly_cnt <= 32'h0000_0000;
      gate_cnt <= 32'h0000_0000;
      runs_left <= 32'h0000_0000;
      sweep_start <= 1'b0;
      sweep_done <= 1'b0;
      acquiring <= 1'b0;
    end
    else
    begin
      sweep_start <= 1'b0;
      sweep_done <= 1'b0;
      if (tick && dly_cnt != 32'h0000_0000)
        dly_cnt <= dly_cnt - 32'd1;
      case (state)
        sweep_pkg::ST_IDLE:
        begin
          if (!single || start_req)
          begin
            state <= sweep_pkg::ST_ARM;
            runs_left <= (avg_cnt == 32'h0000_0000) ? 32'd1 : avg_cnt;
          end
        end
        sweep_pkg::ST_ARM:
        begin
          elapsed <= 32'h0000_0000;
          case (src)
            sweep_pkg::SRC_FREE:
            begin
              state <= sweep_pkg::ST_SWEEP;
              sweep_start <= 1'b1;
              acquiring <= 1'b1;
            end
            sweep_pkg::SRC_VIDEO:
            begin
              if (vid_hit && zero_span)
              begin
                state <= sweep_pkg::ST_DELAY;
                dly_cnt <= trig_dly;
              end
            end
            sweep_pkg::SRC_EXT:
            begin
              if (ext_edge)
              begin
                state <= sweep_pkg::ST_DELAY;
                dly_cnt <= trig_dly;
              end
            end
            default:
            begin
              state <= sweep_pkg::ST_GATE_WAIT;
              sweep_start <= 1'b1;
            end
          endcase
        end
        sweep_pkg::ST_DELAY:
        begin
          if (dly_cnt == 32'h0000_0000)
          begin
            state <= sweep_pkg::ST_SWEEP;
            sweep_start <= 1'b1;
            acquiring <= 1'b1;
          end
        end
        sweep_pkg::ST_SWEEP:
        begin
          if (tick)
            elapsed <= elapsed + 32'd1;
        end
        sweep_pkg::ST_GATE_WAIT:
        begin
          if (gate_on)
          begin
            state <= sweep_pkg::ST_GATE_DLY;
            dly_cnt <= gate_dly;
          end
        end
        sweep_pkg::ST_GATE_DLY:
        begin
          if (dly_cnt == 32'h0000_0000)
          begin
            state <= sweep_pkg::ST_GATE_OPEN;
            gate_cnt <= gate_len;
            acquiring <= 1'b1;
          end
        end
        sweep_pkg::ST_GATE_OPEN:
        begin
          if (tick)
          begin
            elapsed <= elapsed + 32'd1; // resumes where the last window stopped
            gate_cnt <= gate_cnt - 32'd1;
            if (gate_cnt <= 32'd1 && !last_us)
            begin
              state <= sweep_pkg::ST_GATE_WAIT;
              acquiring <= 1'b0;
            end
          end
        end
        default:
          state <= sweep_pkg::ST_IDLE;
      endcase
      // sweep end is shared by plain and gated acquisition
      if ((state == sweep_pkg::ST_SWEEP || state == sweep_pkg::ST_GATE_OPEN) && last_us)
      begin
        sweep_done <= 1'b1;
        acquiring <= 1'b0;
        elapsed <= eff_dur;
        if (single && runs_left <= 32'd1)
          state <= sweep_pkg::ST_IDLE;
        else
          state <= sweep_pkg::ST_ARM;
        if (single)
          runs_left <= runs_left - 32'd1;
      end
    end
  end

  // x axis position in microseconds from sweep start
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      sweep_time_us <= 32'h0000_0000;
    else
      sweep_time_us <= elapsed;
  end

  // axi read channel, one cycle from address to data
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= sweep_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= sweep_pkg::RESP_OKAY;
      if (s_axi_araddr == sweep_pkg::OFF_CTRL) s_axi_rdata <= ctrl;
      else if (s_axi_araddr == sweep_pkg::OFF_SPAN) s_axi_rdata <= span_mhz;
      else if (s_axi_araddr == sweep_pkg::OFF_USER_DUR) s_axi_rdata <= user_dur;
      else if (s_axi_araddr == sweep_pkg::OFF_TRIG_DLY) s_axi_rdata <= trig_dly;
      else if (s_axi_araddr == sweep_pkg::OFF_GATE_DLY) s_axi_rdata <= gate_dly;
      else if (s_axi_araddr == sweep_pkg::OFF_GATE_LEN) s_axi_rdata <= gate_len;
      else if (s_axi_araddr == sweep_pkg::OFF_VID_PCT) s_axi_rdata <= vid_pct;
      else if (s_axi_araddr == sweep_pkg::OFF_AVG) s_axi_rdata <= avg_cnt;
      else if (s_axi_araddr == sweep_pkg::OFF_STATUS)
        s_axi_rdata <= {runs_left[15:0], 8'h00, zero_span, acquiring, start_req, 2'h0, state};
      else if (s_axi_araddr == sweep_pkg::OFF_EFF_DUR) s_axi_rdata <= eff_dur;
      else if (s_axi_araddr == sweep_pkg::OFF_ELAPSED) s_axi_rdata <= elapsed;
      else
      begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= (reg_index(s_axi_araddr) == sweep_pkg::OFF_NONE) ?
                       sweep_pkg::RESP_SLVERR : sweep_pkg::RESP_OKAY;
      end
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // checks on the sequencer
  property p_zs_min;
    @(posedge mclk) disable iff (sys_rst)
    (zero_span && state == sweep_pkg::ST_SWEEP) |-> eff_dur >= sweep_pkg::ZS_MIN_US;
  endproperty
  a_zs_min: assert property (p_zs_min) else $error("zero span duration below floor");
  property p_span_min;
    @(posedge mclk) disable iff (sys_rst)
    $stable(act_span) && $stable(user_dur) && !zero_span |=> eff_dur >= $past(span_floor);
  endproperty
  a_span_min: assert property (p_span_min) else $error("sweep shorter than span allows");
  property p_free_start;
    @(posedge mclk) disable iff (sys_rst)
    (state == sweep_pkg::ST_ARM && src == sweep_pkg::SRC_FREE) |=>
      state == sweep_pkg::ST_SWEEP && sweep_start;
  endproperty
  a_free_start: assert property (p_free_start) else $error("free run did not start");
  property p_video_nz;
    @(posedge mclk) disable iff (sys_rst)
    (state == sweep_pkg::ST_ARM && src == sweep_pkg::SRC_VIDEO && !zero_span) |=>
      state != sweep_pkg::ST_DELAY;
  endproperty
  a_video_nz: assert property (p_video_nz) else $error("video trigger with span");
  property p_single_halt;
    @(posedge mclk) disable iff (sys_rst)
    sweep_done && single && $past(runs_left) <= 32'd1 && $past(single) |->
      state == sweep_pkg::ST_IDLE;
  endproperty
  a_single_halt: assert property (p_single_halt) else $error("single mode kept running");
  property p_cont_restart;
    @(posedge mclk) disable iff (sys_rst)
    sweep_done && !$past(single) |-> state == sweep_pkg::ST_ARM;
  endproperty
  a_cont_restart: assert property (p_cont_restart) else $error("no restart");
  property p_delay_hold;
    @(posedge mclk) disable iff (sys_rst)
    (state == sweep_pkg::ST_DELAY && dly_cnt > 32'd1) |=> state == sweep_pkg::ST_DELAY;
  endproperty
  a_delay_hold: assert property (p_delay_hold) else $error("delay cut short");
  property p_start_origin;
    @(posedge mclk) disable iff (sys_rst)
    sweep_start |-> elapsed == 32'h0000_0000 ##1 sweep_time_us == 32'h0000_0000;
  endproperty
  a_start_origin: assert property (p_start_origin) else $error("axis not at origin");
  property p_gate_zs;
    @(posedge mclk) disable iff (sys_rst)
    gate_setup |-> zero_span;
  endproperty
  a_gate_zs: assert property (p_gate_zs) else $error("gate setup not zero span");
  property p_gate_pause;
    @(posedge mclk) disable iff (sys_rst)
    (state == sweep_pkg::ST_GATE_OPEN && tick && gate_cnt <= 32'd1 && !last_us) |=>
      state == sweep_pkg::ST_GATE_WAIT && !acquiring;
  endproperty
  a_gate_pause: assert property (p_gate_pause) else $error("gate did not close");
  c_free: cover property (@(posedge mclk) sweep_done && src == sweep_pkg::SRC_FREE);
  c_ext: cover property (@(posedge mclk) state == sweep_pkg::ST_DELAY ##1 sweep_start);
  c_gate: cover property (@(posedge mclk) state == sweep_pkg::ST_GATE_OPEN ##1
                          state == sweep_pkg::ST_GATE_WAIT);
endmodule

// >>> verif/trig_source_model.sv
`timescale 1ns/1ps
// far-side trigger or gate source; idle at the inactive level
module trig_source_model (
  input wire logic mclk,
  input wire logic fire,
  input wire logic active_low,
  output logic trig_out
);
  int hold = 0;
  // one active pulse of 8 clocks per request, wider than the 3-flop input path needs
  always_ff @(posedge mclk)
  begin
    if (fire && hold == 0)
      hold <= 8;
    else if (hold != 0)
      hold <= hold - 1;
  end
  // the edge polarity follows the selected slope
  assign trig_out = (hold != 0) ^ active_low;
endmodule

// >>> verif/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, fire = 1'b0, active_low = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic ext_trig_pin, acquiring, sweep_start, sweep_done;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [31:0] s_axi_rdata, sweep_time_us, d;
  logic [11:0] video_level = 12'h000;
  int n_mismatch = 0, compares = 0, c, n;
  logic [31:0] din [4] = '{32'h3E7, 32'h4D2, 32'hDDD5, 32'h75BCD15};
  logic [31:0] dex [4] = '{32'h3DE, 32'h4B0, 32'hDAC0, 32'h5F5E100};
  always #5 mclk = ~mclk;
  sweep_trigger_gate_control DUT (.mclk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .ext_trig_pin, .video_level, .acquiring, .sweep_start, .sweep_done, .sweep_time_us);
  trig_source_model src (.mclk, .fire, .active_low, .trig_out(ext_trig_pin));
  task automatic end_sim;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("BAD %0t seen %h want %h", $time, s, e);
    end
  endtask
  // ready is looked at on the falling edge so the decision lands on the next rising one
  task automatic axw(input logic [7:0] a, input logic [31:0] v);
    logic ah, wh, bh;
    bh = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!bh)
    begin
      @(negedge mclk);
      ah = s_axi_awvalid && s_axi_awready;
      wh = s_axi_wvalid && s_axi_wready;
      bh = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge mclk);
      if (ah)
        s_axi_awvalid <= 1'b0;
      if (wh)
        s_axi_wvalid <= 1'b0;
    end
    // bready stays high between writes so back-to-back calls never drive it twice in one step
  endtask
  task automatic axr(input logic [7:0] a);
    logic ah, rh;
    rh = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!rh)
    begin
      @(negedge mclk);
      ah = s_axi_arvalid && s_axi_arready;
      rh = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge mclk);
      if (ah)
        s_axi_arvalid <= 1'b0;
    end
    // rready stays high between reads for the same reason as bready
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    axr(a);
    chk(d, e);
  endtask
  // cycles until start(0), done(1), acquiring high(2) or low(3)
  task automatic wait_sig(input int w, input int lim, output int k);
    logic [3:0] v;
    k = 0;
    v = 4'h0;
    while (!v[w] && k < lim)
    begin
      @(negedge mclk);
      v = {~acquiring, acquiring, sweep_done, sweep_start};
      k++;
    end
    @(posedge mclk);
  endtask
  task automatic count(input logic w, input int lim, output int k);
    k = 0;
    repeat (lim)
    begin
      @(negedge mclk);
      k += w ? sweep_done : sweep_start;
    end
    @(posedge mclk);
  endtask
  task automatic pulse;
    fire <= 1'b1;
    @(posedge mclk);
    fire <= 1'b0;
  endtask
  initial
  begin
    #900000;
    n_mismatch++;
    end_sim();
  end
  initial
  begin
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    rd(sweep_pkg::OFF_CTRL, sweep_pkg::CTRL_RESET);
    rd(sweep_pkg::OFF_AVG, sweep_pkg::AVG_RESET);
    rd(sweep_pkg::OFF_VID_PCT, sweep_pkg::VID_PCT_RESET);
    axr(8'hFC);
    chk({30'h0, r}, {30'h0, sweep_pkg::RESP_SLVERR});
    axw(8'hFC, 32'h0);
    chk({30'h0, r}, {30'h0, sweep_pkg::RESP_SLVERR});
    axw(sweep_pkg::OFF_GATE_LEN, 32'h0);
    chk({30'h0, r}, {30'h0, sweep_pkg::RESP_OKAY});
    // duration limits: manual below the floor, wide span, coupled rounding up
    axw(sweep_pkg::OFF_CTRL, 32'h20);
    axw(sweep_pkg::OFF_USER_DUR, 32'hA);
    rd(sweep_pkg::OFF_EFF_DUR, 32'h22);
    axw(sweep_pkg::OFF_USER_DUR, 32'h77359400);
    rd(sweep_pkg::OFF_EFF_DUR, 32'h3B9ACA00);
    axw(sweep_pkg::OFF_SPAN, 32'h4B0);
    axw(sweep_pkg::OFF_USER_DUR, 32'hA);
    rd(sweep_pkg::OFF_EFF_DUR, 32'h9C40);
    axw(sweep_pkg::OFF_CTRL, 32'h0);
    axw(sweep_pkg::OFF_SPAN, 32'h1);
    rd(sweep_pkg::OFF_EFF_DUR, 32'h22);
    axw(sweep_pkg::OFF_CTRL, 32'h40);
    axr(sweep_pkg::OFF_STATUS);
    chk(d[7], 1'b1);
    axw(sweep_pkg::OFF_CTRL, 32'h0);
    axr(sweep_pkg::OFF_STATUS);
    chk(d[7], 1'b0);
    rd(sweep_pkg::OFF_SPAN, 32'h1);
    for (int i = 0; i < 4; i++)
    begin
      axw(sweep_pkg::OFF_TRIG_DLY, din[i]);
      rd(sweep_pkg::OFF_TRIG_DLY, dex[i]);
    end
    $display("test registers done");
    // 34 us zero-span sweeps back to back
    axw(sweep_pkg::OFF_SPAN, 32'h0);
    axw(sweep_pkg::OFF_CTRL, 32'h20);
    wait_sig(1, 8000, c);
    wait_sig(0, 8000, c);
    chk(c <= 3, 1'b1);
    wait_sig(1, 8000, c);
    chk(c >= 3390 && c <= 3410, 1'b1);
    // the end value stands for one cycle only, so look mid-cycle
    @(negedge mclk);
    chk(sweep_time_us, 32'h22);
    @(posedge mclk);
    axw(sweep_pkg::OFF_AVG, 32'h2);
    axw(sweep_pkg::OFF_CTRL, 32'h21);
    repeat (4000) @(posedge mclk);
    count(1'b1, 4000, n);
    chk(n, 32'h0);
    axw(sweep_pkg::OFF_CTRL, 32'h23);
    count(1'b1, 12000, n);
    chk(n, 32'h2);
    $display("test modes done");
    // second edge in the 20 us delay must be ignored; both slopes
    axw(sweep_pkg::OFF_TRIG_DLY, 32'h14);
    for (int p = 0; p < 2; p++)
    begin
      active_low <= p[0];
      axw(sweep_pkg::OFF_CTRL, p[0] ? 32'h38 : 32'h28);
      repeat (4000) @(posedge mclk);
      pulse();
      repeat (300) @(posedge mclk);
      pulse();
      wait_sig(0, 4000, c);
      chk(c >= 1600 && c <= 1710, 1'b1);
    end
    active_low <= 1'b0;
    axw(sweep_pkg::OFF_CTRL, 32'h24);
    video_level <= 12'h7FF;
    count(1'b0, 4000, n);
    chk(n, 32'h0);
    video_level <= 12'h800;
    wait_sig(0, 4000, c);
    chk(c >= 1900 && c <= 2010, 1'b1);
    video_level <= 12'h000;
    // let the running sweep end so the video crossing meets the armed state with span
    repeat (4000) @(posedge mclk);
    axw(sweep_pkg::OFF_SPAN, 32'h258);
    video_level <= 12'hFFF;
    count(1'b0, 4000, n);
    chk(n, 32'h0);
    $display("test triggers done");
    // gate windows of 5 us delay and 10 us length over a 34 us sweep
    video_level <= 12'h000;
    axw(sweep_pkg::OFF_SPAN, 32'h0);
    axw(sweep_pkg::OFF_GATE_DLY, 32'h5);
    axw(sweep_pkg::OFF_GATE_LEN, 32'hA);
    axw(sweep_pkg::OFF_CTRL, 32'h2C);
    repeat (4000) @(posedge mclk);
    for (int g = 0; g < 4; g++)
    begin
      pulse();
      wait_sig(2, 3000, c);
      chk(c >= 400 && c <= 510, 1'b1);
      wait_sig(g == 3 ? 1 : 3, 3000, c);
      chk(g == 3 ? c <= 500 : c >= 900 && c <= 1010, 1'b1);
    end
    $display("test gate done");
    end_sim();
  end
endmodule
